// ===== logic/video_timing_pkg.sv
package video_timing_pkg;

    // Timing base: reference clock period
    localparam int CLK_NS = 50;

    // Line timer
    localparam int         CNT_W   = 12;
    localparam logic [11:0] CNT_ZERO = 12'h0000;
    localparam logic [11:0] CNT_ONE  = 12'h0001;
    localparam logic [11:0] CNT_MAX  = 12'h0FFF;

    // Times as printed, in ns
    localparam int HMIN_NTSC_NS   = 4000;
    localparam int HMAX_NTSC_NS   = 5400;
    localparam int HMIN_PAL_NS    = 4200;
    localparam int HMAX_PAL_NS    = 5400;
    localparam int BURST_NTSC_NS  = 5500;
    localparam int BURST_PAL_NS   = 5500;
    localparam int BURST_LEN_NS   = 2500;
    localparam int OFFSET_ST_NS   = 8400;
    localparam int OFFSET_LEN_NS  = 1000;
    localparam int RC_NOM_NS      = 2000;
    localparam int RC_TOL_NS      = 100;

    // Least times round up, longest times round down
    function automatic logic [11:0] ns_up(input int ns);
        ns_up = 12'((ns + CLK_NS - 1) / CLK_NS);
    endfunction : ns_up

    function automatic logic [11:0] ns_dn(input int ns);
        ns_dn = 12'(ns / CLK_NS);
    endfunction : ns_dn

    localparam logic [11:0] HMIN_NTSC_CYC  = ns_up(HMIN_NTSC_NS);
    localparam logic [11:0] HMAX_NTSC_CYC  = ns_dn(HMAX_NTSC_NS);
    localparam logic [11:0] HMIN_PAL_CYC   = ns_up(HMIN_PAL_NS);
    localparam logic [11:0] HMAX_PAL_CYC   = ns_dn(HMAX_PAL_NS);
    localparam logic [11:0] BURST_NTSC_CYC = ns_up(BURST_NTSC_NS);
    localparam logic [11:0] BURST_PAL_CYC  = ns_up(BURST_PAL_NS);
    localparam logic [11:0] BURST_LEN_CYC  = ns_dn(BURST_LEN_NS);
    localparam logic [11:0] OFFSET_ST_CYC  = ns_up(OFFSET_ST_NS);
    localparam logic [11:0] OFFSET_LEN_CYC = ns_dn(OFFSET_LEN_NS);
    localparam logic [11:0] RC_NOM_CYC     = ns_dn(RC_NOM_NS);
    localparam logic [11:0] RC_TOL_CYC     = ns_dn(RC_TOL_NS);

    // Burst phase codes
    localparam logic [1:0] BURST_PH_180 = 2'h0;
    localparam logic [1:0] BURST_PH_135 = 2'h1;
    localparam logic [1:0] BURST_PH_225 = 2'h2;

    // Quadrature phase step
    localparam logic [1:0] QUAD_STEP = 2'h1;

    typedef enum logic [1:0] {
        RC_IDLE_S  = 2'b00,
        RC_WAIT_S  = 2'b01,
        RC_JUDGE_S = 2'b10
    } rc_state_type;

endpackage : video_timing_pkg

// ===== logic/video_encoder_sync_timing.sv
`timescale 1ns/1ps

module video_encoder_sync_timing (
    // Clock and reset
    input  wire logic       REF_CLK_I,
    input  wire logic       SYS_RST_I,
    // Sync inputs from the controller
    input  wire logic       LINE_SYNC_I,
    input  wire logic       FRAME_SYNC_I,
    // Mode straps
    input  wire logic       STANDARD_SELECT_I,
    input  wire logic       SOUTH_AMERICA_MODE_I,
    // Filter tuning handshake
    input  wire logic       RC_DONE_I,
    output logic            RC_START_O,
    output logic            CUTOFF_UP_O,
    output logic            CUTOFF_DOWN_O,
    // Sync and line timing
    output logic            LUMA_SYNC_O,
    output logic            VBLANK_O,
    output logic            BURST_GATE_O,
    output logic            CLAMP_O,
    output logic            DL_CLK_RESET_O,
    output logic            LUMA_HOLD_O,
    output logic            OFFSET_CANCEL_O,
    // Carriers and burst phase
    output logic            SINE_O,
    output logic            COSINE_O,
    output logic            V_INVERT_O,
    output logic [1:0]      BURST_PHASE_O
);
    import video_timing_pkg::*;

    logic              phase_q;
    logic              csync_q;
    logic              csync_prev_q;
    logic              fall;
    logic              rise;
    logic [CNT_W-1:0]  cnt_q;
    logic              meas_q;
    logic              std_q;
    logic              vblank_q;
    logic              vblank_prev_q;
    logic              ntsc_timing;
    logic              alternate;
    logic [CNT_W-1:0]  hmin;
    logic [CNT_W-1:0]  hmax;
    logic [CNT_W-1:0]  burst_start;
    logic              width_ok;
    logic              burst_win;
    logic              offset_win;
    logic [1:0]        quad_q;
    logic [1:0]        quad_d;
    logic              vinv_q;
    logic              vinv_d;
    logic              burst_q;
    logic              offset_q;
    logic [1:0]        bph_q;
    logic              cos_q;
    rc_state_type      rc_state_q;
    logic [CNT_W-1:0]  rc_cnt_q;
    logic              rc_start_q;
    logic              up_q;
    logic              down_q;

    // True while cnt lies in [start, start+len)
    function automatic logic in_win(input logic [11:0] cnt,
                                    input logic [11:0] start,
                                    input logic [11:0] len);
        in_win = (cnt >= start) &&
                 ({1'b0, cnt} < ({1'b0, start} + {1'b0, len}));
    endfunction : in_win

    // SA keeps NTSC timing but alternates like PAL
    assign ntsc_timing = STANDARD_SELECT_I;
    assign alternate   = ~STANDARD_SELECT_I | SOUTH_AMERICA_MODE_I;

    // Per-standard constants, all at the 20 MHz timing base
    assign hmin        = ntsc_timing ? HMIN_NTSC_CYC : HMIN_PAL_CYC;
    assign hmax        = ntsc_timing ? HMAX_NTSC_CYC : HMAX_PAL_CYC;
    assign burst_start = ntsc_timing ? BURST_NTSC_CYC
                                     : BURST_PAL_CYC;

    // Half-rate sampling; XNOR gives low-going pulses in both sync modes
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            phase_q      <= 1'b0;
            csync_q      <= 1'b1;
            csync_prev_q <= 1'b1;
        end else begin
            phase_q      <= ~phase_q;
            if (phase_q) begin
                csync_q <= LINE_SYNC_I ~^ FRAME_SYNC_I;
            end
            csync_prev_q <= csync_q;
        end
    end

    assign fall = csync_prev_q & ~csync_q;
    assign rise = ~csync_prev_q & csync_q;

    assign width_ok = (cnt_q >= hmin) && (cnt_q <= hmax);

    // Line timer from each falling edge, saturating
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            cnt_q <= CNT_MAX;
        end else if (fall) begin
            cnt_q <= CNT_ZERO;
        end else if (cnt_q != CNT_MAX) begin
            cnt_q <= cnt_q + CNT_ONE;
        end
    end

    // Width judgement at the rising edge; overlong pulses judged early
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            meas_q   <= 1'b0;
            std_q    <= 1'b0;
            vblank_q <= 1'b1;
        end else if (fall) begin
            meas_q <= 1'b1;
            std_q  <= 1'b0;
        end else if (meas_q && rise) begin
            meas_q   <= 1'b0;
            std_q    <= width_ok;
            vblank_q <= ~width_ok;
        end else if (meas_q && cnt_q > hmax) begin
            meas_q   <= 1'b0;
            vblank_q <= 1'b1;
        end
    end

    // Burst, clamp and delay-line reset share one window
    assign burst_win  = std_q &&
                        in_win(cnt_q, burst_start, BURST_LEN_CYC);
    assign offset_win = in_win(cnt_q, OFFSET_ST_CYC, OFFSET_LEN_CYC);

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            burst_q  <= 1'b0;
            offset_q <= 1'b0;
        end else begin
            burst_q  <= burst_win;
            offset_q <= offset_win;
        end
    end

    // Quarter-rate quadrature pair; V flips per line when alternating
    assign quad_d = quad_q + QUAD_STEP;
    assign vinv_d = (fall && alternate) ? ~vinv_q : vinv_q;

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            quad_q <= 2'h0;
            vinv_q <= 1'b0;
            cos_q  <= 1'b0;
        end else begin
            quad_q <= quad_d;
            vinv_q <= vinv_d;
            cos_q  <= (quad_d[1] ^ quad_d[0]) ^ vinv_d;
        end
    end

    // Burst vector follows the V phase of the current line
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            bph_q <= BURST_PH_180;
        end else if (!alternate) begin
            bph_q <= BURST_PH_180;
        end else begin
            bph_q <= vinv_d ? BURST_PH_225 : BURST_PH_135;
        end
    end

    // Filter retune once per entry into vertical blanking
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            vblank_prev_q <= 1'b1;
            rc_state_q    <= RC_IDLE_S;
            rc_cnt_q      <= CNT_ZERO;
            rc_start_q    <= 1'b0;
            up_q          <= 1'b0;
            down_q        <= 1'b0;
        end else begin
            vblank_prev_q <= vblank_q;
            rc_start_q    <= 1'b0;
            up_q          <= 1'b0;
            down_q        <= 1'b0;
            unique case (rc_state_q)
                RC_IDLE_S: begin
                    if (vblank_q && !vblank_prev_q) begin
                        rc_start_q <= 1'b1;
                        rc_cnt_q   <= CNT_ZERO;
                        rc_state_q <= RC_WAIT_S;
                    end
                end
                RC_WAIT_S: begin
                    // Leaving blanking or no answer abandons the check
                    if (!vblank_q || rc_cnt_q == CNT_MAX) begin
                        rc_state_q <= RC_IDLE_S;
                    end else if (RC_DONE_I) begin
                        rc_state_q <= RC_JUDGE_S;
                    end else begin
                        rc_cnt_q <= rc_cnt_q + CNT_ONE;
                    end
                end
                RC_JUDGE_S: begin
                    // Short RC means cutoff too high, and the reverse
                    down_q     <= rc_cnt_q <
                                  (RC_NOM_CYC - RC_TOL_CYC);
                    up_q       <= rc_cnt_q >
                                  (RC_NOM_CYC + RC_TOL_CYC);
                    rc_state_q <= RC_IDLE_S;
                end
                default: begin
                    rc_state_q <= RC_IDLE_S;
                end
            endcase
        end
    end

    assign LUMA_SYNC_O     = csync_q;
    assign VBLANK_O        = vblank_q;
    assign BURST_GATE_O    = burst_q;
    assign CLAMP_O         = burst_q;
    // Delay line runs at 2x externally; this only stops and restarts it
    assign DL_CLK_RESET_O  = burst_q;
    assign LUMA_HOLD_O     = burst_q;
    assign OFFSET_CANCEL_O = offset_q;
    assign SINE_O          = quad_q[1];
    assign COSINE_O        = cos_q;
    assign V_INVERT_O      = vinv_q;
    assign BURST_PHASE_O   = bph_q;
    assign RC_START_O      = rc_start_q;
    assign CUTOFF_UP_O     = up_q;
    assign CUTOFF_DOWN_O   = down_q;

endmodule : video_encoder_sync_timing

// ===== testbench/video_timing_assertions.sv
`timescale 1ns/1ps
module video_timing_assertions (
    // Clock and reset
    input  wire logic       REF_CLK_I,
    input  wire logic       SYS_RST_I,
    // Inputs
    input  wire logic       LINE_SYNC_I,
    input  wire logic       FRAME_SYNC_I,
    input  wire logic       STANDARD_SELECT_I,
    input  wire logic       SOUTH_AMERICA_MODE_I,
    // Outputs
    input  wire logic       RC_START_O,
    input  wire logic       LUMA_SYNC_O,
    input  wire logic       VBLANK_O,
    input  wire logic       BURST_GATE_O,
    input  wire logic       CLAMP_O,
    input  wire logic       DL_CLK_RESET_O,
    input  wire logic       LUMA_HOLD_O,
    input  wire logic       OFFSET_CANCEL_O,
    input  wire logic       SINE_O,
    input  wire logic       COSINE_O,
    input  wire logic       V_INVERT_O,
    input  wire logic [1:0] BURST_PHASE_O
);
    import video_timing_pkg::*;
    logic alt;
    // Alternation in PAL and in South America mode
    assign alt = !STANDARD_SELECT_I || SOUTH_AMERICA_MODE_I;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_sync_xnor: assert property ($changed(LUMA_SYNC_O) |->
        LUMA_SYNC_O == ($past(LINE_SYNC_I) ~^ $past(FRAME_SYNC_I)))
        else $error("luma sync not xnor of inputs");
    a_gates_tied: assert property (CLAMP_O == BURST_GATE_O &&
        DL_CLK_RESET_O == BURST_GATE_O && LUMA_HOLD_O == BURST_GATE_O)
        else $error("clamp or hold apart from burst");
    a_offset_start: assert property ($fell(LUMA_SYNC_O) |->
        ##170 $rose(OFFSET_CANCEL_O)) else $error("offset cancel misplaced");
    a_burst_offset: assert property ($rose(BURST_GATE_O) |->
        ##58 $rose(OFFSET_CANCEL_O)) else $error("burst start misplaced");
    a_burst_vblank: assert property ($rose(BURST_GATE_O) |->
        !VBLANK_O) else $error("burst in vertical blanking");
    a_vblank_rc: assert property ($rose(VBLANK_O) |->
        ##[1:2] RC_START_O) else $error("no filter check");
    a_quad_period: assert property (!($past(SYS_RST_I) ||
        $past(SYS_RST_I, 2) || $past(SYS_RST_I, 3)) |->
        SINE_O != $past(SINE_O, 2)) else $error("carrier period wrong");
    a_v_flip: assert property ($fell(LUMA_SYNC_O) && alt |->
        ##[0:3] $changed(V_INVERT_O)) else $error("V carrier not flipped");
    a_burst_phase: assert property (BURST_GATE_O |->
        BURST_PHASE_O == (!alt ? BURST_PH_180 :
        V_INVERT_O ? BURST_PH_225 : BURST_PH_135))
        else $error("burst phase wrong");
    a_carrier_quad: assert property (
        $past(COSINE_O) == (SINE_O ^ $past(V_INVERT_O)))
        else $error("cosine not in quadrature with sine");
endmodule : video_timing_assertions

bind video_encoder_sync_timing video_timing_assertions u_checker (
    .REF_CLK_I, .SYS_RST_I, .LINE_SYNC_I, .FRAME_SYNC_I,
    .STANDARD_SELECT_I, .SOUTH_AMERICA_MODE_I, .RC_START_O,
    .LUMA_SYNC_O, .VBLANK_O, .BURST_GATE_O, .CLAMP_O, .DL_CLK_RESET_O,
    .LUMA_HOLD_O, .OFFSET_CANCEL_O, .SINE_O, .COSINE_O, .V_INVERT_O,
    .BURST_PHASE_O
);

// ===== testbench/sync_source.sv
`timescale 1ns/1ps
module sync_source (
    // Bench commands
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] width_i,
    input  wire logic       frame_i,
    input  wire logic [7:0] rc_dly_i,
    // Device side
    input  wire logic       rc_start_i,
    output logic            line_sync_o,
    output logic            frame_sync_o,
    output logic            rc_done_o
);
    logic [7:0] low_q  = 8'h00;
    logic [7:0] rc_q   = 8'h00;
    logic       done_q = 1'b0;
    // Idle input held high, pulse on one input only
    assign line_sync_o  = !(low_q != 8'h00 && !frame_i);
    assign frame_sync_o = !(low_q != 8'h00 && frame_i);
    assign rc_done_o    = done_q;
    always @(posedge clk_i) begin
        low_q <= go_i ? width_i : low_q - 8'(low_q != 8'h00);
    end
    // Timer answers after the commanded delay
    always @(posedge clk_i) begin
        rc_q   <= rc_start_i ? rc_dly_i : rc_q - 8'(rc_q != 8'h00);
        done_q <= rc_q == 8'h01;
    end
endmodule : sync_source

// ===== testbench/video_encoder_sync_timing_tb.sv
`timescale 1ns/1ps
module video_encoder_sync_timing_tb;
    import video_timing_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       ntsc = 1'b1;
    logic       sa = 1'b0;
    logic       go = 1'b0;
    logic       frm = 1'b0;
    logic [7:0] wid = 8'h00;
    logic [7:0] dly = 8'h00;
    logic       ls, fs, rdone, rstart, up, dn, lsync, vb, burst;
    logic       clamp, dlr, hold, offs, sine, cosine, vinv;
    logic [1:0] phase;
    int         failures = 0;
    int         check_count = 0;
    always #25 clk = ~clk;
    video_encoder_sync_timing DUT (
        .REF_CLK_I(clk), .SYS_RST_I(rst), .LINE_SYNC_I(ls),
        .FRAME_SYNC_I(fs), .STANDARD_SELECT_I(ntsc),
        .SOUTH_AMERICA_MODE_I(sa), .RC_DONE_I(rdone),
        .RC_START_O(rstart), .CUTOFF_UP_O(up), .CUTOFF_DOWN_O(dn),
        .LUMA_SYNC_O(lsync), .VBLANK_O(vb), .BURST_GATE_O(burst),
        .CLAMP_O(clamp), .DL_CLK_RESET_O(dlr), .LUMA_HOLD_O(hold),
        .OFFSET_CANCEL_O(offs), .SINE_O(sine), .COSINE_O(cosine),
        .V_INVERT_O(vinv), .BURST_PHASE_O(phase)
    );
    sync_source partner (
        .clk_i(clk), .go_i(go), .width_i(wid), .frame_i(frm),
        .rc_dly_i(dly), .rc_start_i(rstart), .line_sync_o(ls),
        .frame_sync_o(fs), .rc_done_o(rdone)
    );
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic t_reset();
        check(12'({lsync, vb}), 12'h003);
        check(12'({burst, clamp, dlr, hold}), 12'h000);
        check(12'({offs, rstart, up, dn}), 12'h000);
        check(12'({sine, cosine, vinv, phase}), 12'(BURST_PH_180));
        $display("reset test done");
    endtask : t_reset
    task automatic t_carrier();
        logic [7:0] s;
        logic [7:0] c;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            s[i] = sine;
            c[i] = cosine;
        end
        check(12'(s ^ {s[1:0], s[7:2]}), 12'h0ff);
        check(12'(c ^ {c[1:0], c[7:2]}), 12'h0ff);
        $display("carrier test done");
    endtask : t_carrier
    // One line: sync pulse of w cycles, then watch the line's windows
    task automatic t_line(input logic [7:0] w, input logic f,
                          input logic std, input logic [7:0] d,
                          input logic [1:0] ud);
        int         nb;
        int         no;
        int         nm;
        logic [1:0] sud;
        logic [1:0] ph;
        logic       v0;
        logic       alt;
        nb = 0;
        no = 0;
        nm = 0;
        sud = 2'b00;
        ph = 2'b11;
        v0 = vinv;
        @(posedge clk);
        go <= 1'b1;
        wid <= w;
        frm <= f;
        dly <= d;
        @(posedge clk);
        go <= 1'b0;
        alt = !ntsc || sa;
        repeat (300) begin
            @(posedge clk);
            #1;
            if (burst === 1'b1) nb++;
            if (burst === 1'b1) ph = phase;
            if (offs === 1'b1) no++;
            if ({clamp, dlr, hold} !== {3{burst}}) nm++;
            sud = sud | {up, dn};
        end
        @(posedge clk);
        check(12'(nb), std ? 12'h032 : 12'h000);
        check(12'(no), 12'h014);
        check(12'(nm), 12'h000);
        check(12'({vb, sud}), 12'({!std, ud}));
        check(12'(vinv), 12'(v0 ^ alt));
        if (std) check(12'(ph), 12'(!alt ? BURST_PH_180 :
            vinv ? BURST_PH_225 : BURST_PH_135));
        $display("line test w=%0d done", w);
    endtask : t_line
    initial begin
        repeat (20) @(posedge clk);
        #1;
        t_reset();
        @(posedge clk);
        rst <= 1'b0;
        t_carrier();
        t_line(8'h5e, 1'b0, 1'b1, 8'h28, 2'b00);
        t_line(8'h28, 1'b0, 1'b0, 8'h1e, 2'b01);
        t_line(8'h5e, 1'b1, 1'b1, 8'h28, 2'b00);
        t_line(8'h82, 1'b0, 1'b0, 8'h37, 2'b10);
        ntsc <= 1'b0;
        t_line(8'h5e, 1'b0, 1'b1, 8'h28, 2'b00);
        t_line(8'h5e, 1'b0, 1'b1, 8'h28, 2'b00);
        t_line(8'h28, 1'b0, 1'b0, 8'h28, 2'b00);
        ntsc <= 1'b1;
        sa <= 1'b1;
        t_line(8'h5e, 1'b0, 1'b1, 8'h28, 2'b00);
        t_line(8'h5e, 1'b0, 1'b1, 8'h28, 2'b00);
        print_verdict();
    end
endmodule : video_encoder_sync_timing_tb
